// ### cmr_pkg.sv
// package: register map, field layout and reset values of the clock mode block
package cmr_pkg;
  localparam logic [7:0] OFF_PCLK_SET0 = 8'h10;
  localparam logic [7:0] OFF_PCLK_SET1 = 8'h14;
  localparam logic [7:0] OFF_PCLK_CLR0 = 8'h18;
  localparam logic [7:0] OFF_PCLK_CLR1 = 8'h1C;
  localparam logic [7:0] OFF_PCLK_STAT0 = 8'h20;
  localparam logic [7:0] OFF_PCLK_STAT1 = 8'h24;
  localparam logic [7:0] OFF_MODE0 = 8'h28;
  localparam logic [7:0] OFF_MODE1 = 8'h2C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h30;
  localparam logic [7:0] OFF_IRQ_RAW = 8'h34;
  localparam logic [7:0] OFF_IRQ_MASKED = 8'h38;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h3C;

  localparam logic [31:0] PCLK0_RST = 32'h0000000C;
  localparam logic [31:0] PCLK0_WMASK = 32'hEFFFFFFF;
  localparam logic [31:0] PCLK1_WMASK = 32'h000003FF;
  localparam logic [31:0] MODE0_RST = 32'h0000084B;
  localparam logic [31:0] MODE0_WMASK = 32'h00007EFF;
  localparam logic [31:0] MODE1_RST = 32'h00020310;
  localparam logic [31:0] IRQ_MASK_WMASK = 32'h0005F09F;
  localparam logic [31:0] IRQ_RAW_WMASK = 32'h0007F09F;
  localparam logic [31:0] IRQ_RAW_RST = 32'h0000001F;

  localparam int VD_RL_LSB = 0;
  localparam int VD_RST_EN_BIT = 3;
  localparam int VD_IL_LSB = 4;
  localparam int VD_IRQ_EN_BIT = 7;
  localparam int EVT_BIT = 9;
  localparam int SYSTICK_EN_BIT = 10;
  localparam int VD_PWR_BIT = 11;
  localparam int CLOCK_OUTPUT_SELECT_LSB = 12;
  localparam int SYS_LSB = 0;
  localparam int WDT_LSB = 4;
  localparam int FRT_LSB = 8;
  localparam int STT_LSB = 12;
  localparam int LCD_LSB = 16;
  localparam int IRQ_SW_STABLE = 4;
  localparam int IRQ_VDET = 16;
  localparam int IRQ_VDET_RST = 17;
  localparam int IRQ_COMMAND_ERROR_FLAG = 18;
  localparam int IRQ_FAIL_LSB = 12;
  localparam int IRQ_PLL = 7;

  localparam logic [2:0] SRC_EXT_MAIN = 3'h0;
  localparam logic [2:0] SRC_INT_MAIN = 3'h1;
  localparam logic [2:0] SRC_EXT_SUB = 3'h2;
  localparam logic [2:0] SRC_INT_SUB = 3'h3;
  localparam logic [2:0] SRC_PLL = 3'h4;
  localparam logic [2:0] SYS_EXT_SUB = 3'h0;
  localparam logic [2:0] SYS_EXT_MAIN = 3'h1;
  localparam logic [2:0] SYS_INT_SUB = 3'h2;
  localparam logic [2:0] SYS_INT_MAIN = 3'h3;
  localparam logic [2:0] SYS_PLL = 3'h4;
  localparam logic [2:0] VD_LVL_MIN = 3'h3;
  localparam logic [2:0] VD_LVL_MAX = 3'h6;
  localparam logic [2:0] CLOCK_OUTPUT_SELECT_RSVD = 3'h5;

  localparam int SW_SETTLE_CYCLES = 4;
endpackage

// ### cmr_system_clock_select_switch.sv
// system clock switch sequencer raising a stable pulse when done
`timescale 1ns/10ps
module cmr_system_clock_select_switch #(
  parameter int SETTLE = cmr_pkg::SW_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic new_src_ready,
  output logic busy,
  output logic done
);
  typedef enum logic [1:0] {IDLE, WAIT_SRC, SETTLING} cmr_sw_state_t;
  cmr_sw_state_t state_r;
  cmr_sw_state_t state_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  wire logic settle_end;

  assign settle_end = (cnt_r == 8'(SETTLE - 1));
  assign busy = (state_r != IDLE);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      IDLE: begin
        cnt_nxt = 8'h00;
        if (start) begin
          state_nxt = WAIT_SRC;
        end
      end
      WAIT_SRC: begin
        if (new_src_ready) begin
          state_nxt = SETTLING;
        end
      end
      SETTLING: begin
        cnt_nxt = cnt_r + 8'h01;
        if (settle_end) begin
          state_nxt = IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= IDLE;
      cnt_r <= 8'h00;
      done <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      done <= (state_r == SETTLING) && settle_end;
    end
  end
endmodule

// ### cmr_vdet_ctrl.sv
// voltage detector action logic: reset and interrupt decisions
`timescale 1ns/10ps
module cmr_vdet_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] reset_level,
  input wire logic [2:0] irq_level,
  input wire logic reset_enable,
  input wire logic irq_enable,
  input wire logic power_up,
  input wire logic [3:0] level_crossed,
  output logic vdet_power,
  output logic vdet_chip_reset,
  output logic vdet_irq_event,
  output logic vdet_reset_seen
);
  wire logic [1:0] rl_idx;
  wire logic [1:0] il_idx;
  wire logic rl_hit;
  wire logic il_hit;
  logic il_hit_r;

  assign rl_idx = 2'(reset_level - cmr_pkg::VD_LVL_MIN);
  assign il_idx = 2'(irq_level - cmr_pkg::VD_LVL_MIN);
  assign rl_hit = power_up && level_crossed[rl_idx];
  assign il_hit = power_up && level_crossed[il_idx];
  assign vdet_power = power_up;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vdet_chip_reset <= 1'b0;
      vdet_irq_event <= 1'b0;
      vdet_reset_seen <= 1'b0;
      il_hit_r <= 1'b0;
    end else begin
      // equal levels let an irq-level detection act as a reset
      vdet_chip_reset <= (rl_hit && reset_enable)
        || (il_hit && reset_enable && irq_level == reset_level);
      vdet_irq_event <= il_hit && !il_hit_r && irq_enable;
      vdet_reset_seen <= rl_hit;
      il_hit_r <= il_hit;
    end
  end
endmodule

// ### cmr_clock_mode_regs.sv
// clock manager mode, gating and interrupt mask registers on apb
`timescale 1ns/10ps
// Functional notes
// - status bit 1 means peripheral bus clock connected; gated peripheral ignores writes
// - first status word resets to 0x0C: watchdog and free-run clocks on
// - writing 1 to a clear-word bit gates that clock; 0 does nothing
// - detector reset level bits 2:0, codes 011..110, reset 011
// - bit 3 enables detector chip reset, resets to 1
// - detector interrupt level bits 6:4, same codes, reset 100
// - equal interrupt and reset levels make a detection reset the chip
// - bit 7 enables detector interrupt, resets to 0
// - bit 9 set pulses the processor receive-event input; resets to 0
// - bit 11 powers detector, reset 1; powered down disables its actions
// - clock output selector bits 14:12 picks seven sources, code 101 reserved and dropped, resets to 000
// - system clock selector bits 2:0 codes 000..100 pick five sources
// - prohibited system clock codes leave selector and clock unchanged
// - finished system clock switch sets switching-stable status
// - low two system clock selector bits reset from boot clock option
// - watchdog selector bits 6:4 five sources else off, resets 001
// - selecting a disabled source keeps old value, sets command error
// - free-run timer selector bits 10:8 same coding, resets 011
// - stamp timer selector bits 14:12 only four oscillators, resets 000
// - lcd selector bits 18:16 same coding, resets 010
// - mask bits read back, 1 enables, 0 masks, reset 0
// - interrupt bit placement: 0-4, 7, 12-15, 16, 18
// - masked status is raw and mask; writes ignored
// - writing 1 to clear register clears raw bit; 0 no effect
module cmr_clock_mode_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] boot_clock_option,
  input wire logic [4:0] src_enabled,
  input wire logic [4:0] src_stable_evt,
  input wire logic [3:0] fail_evt,
  input wire logic [3:0] vdet_level_crossed,
  output logic [31:0] periph_clk_en0,
  output logic [31:0] periph_clk_en1,
  output logic [2:0] system_clock_select,
  output logic system_clock_switching,
  output logic [2:0] watchdog_clock_select,
  output logic [2:0] freerun_timer_clock_select,
  output logic [2:0] stamp_timer_clock_select,
  output logic [2:0] lcd_clock_select,
  output logic [2:0] clock_output_select,
  output logic systick_clock_enable,
  output logic processor_event_pulse,
  output logic vdet_power_up,
  output logic vdet_chip_reset,
  output logic command_error_flag,
  output logic cm_irq
);
  logic [31:0] pclk0_r;
  logic [31:0] pclk1_r;
  logic [31:0] mode0_r;
  logic [31:0] mode1_r;
  logic [31:0] mask_r;
  logic [31:0] raw_r;
  logic [31:0] raw_nxt;
  logic [31:0] mode1_nxt;
  logic boot_load_r;
  logic evt_arm_r;
  logic cmd_err_nxt;
  logic [31:0] prdata_nxt;

  wire logic wr;
  wire logic rd;
  wire logic [31:0] masked;
  wire logic [2:0] sys_req;
  wire logic sys_legal;
  wire logic sys_changes;
  wire logic sys_start;
  wire logic sw_busy;
  wire logic sw_done;
  wire logic vd_irq_evt;
  wire logic vd_rst_seen;
  wire logic known_addr;
  wire logic [31:0] mode0_wr;

  // true when a peripheral selector code may be taken; disconnect codes always pass
  function automatic logic src_ok(input logic [2:0] code, input logic [4:0] en,
                                  input logic allow_pll);
    if (code <= cmr_pkg::SRC_INT_SUB) begin
      src_ok = en[code];
    end else if (code == cmr_pkg::SRC_PLL && allow_pll) begin
      src_ok = en[code];
    end else begin
      src_ok = 1'b1;
    end
  endfunction

  // system code to source enable index
  function automatic logic sys_ok(input logic [2:0] code, input logic [4:0] en);
    unique case (code)
      cmr_pkg::SYS_EXT_SUB: sys_ok = en[cmr_pkg::SRC_EXT_SUB];
      cmr_pkg::SYS_EXT_MAIN: sys_ok = en[cmr_pkg::SRC_EXT_MAIN];
      cmr_pkg::SYS_INT_SUB: sys_ok = en[cmr_pkg::SRC_INT_SUB];
      cmr_pkg::SYS_INT_MAIN: sys_ok = en[cmr_pkg::SRC_INT_MAIN];
      default: sys_ok = en[cmr_pkg::SRC_PLL];
    endcase
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign known_addr = paddr[1:0] == 2'h0 && paddr >= cmr_pkg::OFF_PCLK_SET0
    && paddr <= cmr_pkg::OFF_IRQ_CLEAR;
  assign masked = raw_r & mask_r;
  assign cm_irq = |masked;

  assign sys_req = pwdata[cmr_pkg::SYS_LSB +: 3];
  assign sys_legal = sys_req <= cmr_pkg::SYS_PLL;
  assign sys_changes = sys_req != mode1_r[cmr_pkg::SYS_LSB +: 3];
  assign sys_start = wr && paddr == cmr_pkg::OFF_MODE1 && sys_legal && sys_changes
    && sys_ok(sys_req, src_enabled) && !sw_busy;

  // a reserved clock output code is dropped so the pin never sees it
  assign mode0_wr = (pwdata[cmr_pkg::CLOCK_OUTPUT_SELECT_LSB +: 3] == cmr_pkg::CLOCK_OUTPUT_SELECT_RSVD)
    ? ((pwdata & cmr_pkg::MODE0_WMASK & ~(32'h00000007 << cmr_pkg::CLOCK_OUTPUT_SELECT_LSB))
       | (mode0_r & (32'h00000007 << cmr_pkg::CLOCK_OUTPUT_SELECT_LSB)))
    : (pwdata & cmr_pkg::MODE0_WMASK);

  cmr_system_clock_select_switch u_sw (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(sys_start),
    .new_src_ready(sys_ok(mode1_r[cmr_pkg::SYS_LSB +: 3], src_enabled)),
    .busy(sw_busy),
    .done(sw_done)
  );

  cmr_vdet_ctrl u_vd (
    .clk(clk),
    .sys_rst(sys_rst),
    .reset_level(mode0_r[cmr_pkg::VD_RL_LSB +: 3]),
    .irq_level(mode0_r[cmr_pkg::VD_IL_LSB +: 3]),
    .reset_enable(mode0_r[cmr_pkg::VD_RST_EN_BIT]),
    .irq_enable(mode0_r[cmr_pkg::VD_IRQ_EN_BIT]),
    .power_up(mode0_r[cmr_pkg::VD_PWR_BIT]),
    .level_crossed(vdet_level_crossed),
    .vdet_power(vdet_power_up),
    .vdet_chip_reset(vdet_chip_reset),
    .vdet_irq_event(vd_irq_evt),
    .vdet_reset_seen(vd_rst_seen)
  );

  // each selector field checked on its own; a bad one keeps old value
  always_comb begin
    mode1_nxt = mode1_r;
    cmd_err_nxt = 1'b0;
    if (wr && paddr == cmr_pkg::OFF_MODE1) begin
      if (sys_start) begin
        mode1_nxt[cmr_pkg::SYS_LSB +: 3] = sys_req;
      end else if (sys_legal && sys_changes) begin
        cmd_err_nxt = 1'b1;
      end
      if (src_ok(pwdata[cmr_pkg::WDT_LSB +: 3], src_enabled, 1'b1)) begin
        mode1_nxt[cmr_pkg::WDT_LSB +: 3] = pwdata[cmr_pkg::WDT_LSB +: 3];
      end else begin
        cmd_err_nxt = 1'b1;
      end
      if (src_ok(pwdata[cmr_pkg::FRT_LSB +: 3], src_enabled, 1'b1)) begin
        mode1_nxt[cmr_pkg::FRT_LSB +: 3] = pwdata[cmr_pkg::FRT_LSB +: 3];
      end else begin
        cmd_err_nxt = 1'b1;
      end
      if (src_ok(pwdata[cmr_pkg::STT_LSB +: 3], src_enabled, 1'b0)) begin
        mode1_nxt[cmr_pkg::STT_LSB +: 3] = pwdata[cmr_pkg::STT_LSB +: 3];
      end else begin
        cmd_err_nxt = 1'b1;
      end
      if (src_ok(pwdata[cmr_pkg::LCD_LSB +: 3], src_enabled, 1'b1)) begin
        mode1_nxt[cmr_pkg::LCD_LSB +: 3] = pwdata[cmr_pkg::LCD_LSB +: 3];
      end else begin
        cmd_err_nxt = 1'b1;
      end
    end
  end

  // hardware sets win over a same-cycle software clear
  always_comb begin
    raw_nxt = raw_r;
    if (wr && paddr == cmr_pkg::OFF_IRQ_CLEAR) begin
      raw_nxt = raw_r & ~(pwdata & cmr_pkg::IRQ_RAW_WMASK);
    end
    raw_nxt[3:0] = raw_nxt[3:0] | src_stable_evt[3:0];
    raw_nxt[cmr_pkg::IRQ_PLL] = raw_nxt[cmr_pkg::IRQ_PLL] | src_stable_evt[4];
    raw_nxt[cmr_pkg::IRQ_SW_STABLE] = raw_nxt[cmr_pkg::IRQ_SW_STABLE] | sw_done;
    raw_nxt[cmr_pkg::IRQ_FAIL_LSB +: 4] = raw_nxt[cmr_pkg::IRQ_FAIL_LSB +: 4] | fail_evt;
    raw_nxt[cmr_pkg::IRQ_VDET] = raw_nxt[cmr_pkg::IRQ_VDET] | vd_irq_evt;
    raw_nxt[cmr_pkg::IRQ_VDET_RST] = raw_nxt[cmr_pkg::IRQ_VDET_RST] | vd_rst_seen;
    raw_nxt[cmr_pkg::IRQ_COMMAND_ERROR_FLAG] = raw_nxt[cmr_pkg::IRQ_COMMAND_ERROR_FLAG] | cmd_err_nxt;
  end

  always_comb begin
    prdata_nxt = 32'h00000000;
    unique case (paddr)
      cmr_pkg::OFF_PCLK_STAT0: prdata_nxt = pclk0_r;
      cmr_pkg::OFF_PCLK_STAT1: prdata_nxt = pclk1_r;
      cmr_pkg::OFF_MODE0: prdata_nxt = mode0_r;
      cmr_pkg::OFF_MODE1: prdata_nxt = mode1_r;
      cmr_pkg::OFF_IRQ_MASK: prdata_nxt = mask_r;
      cmr_pkg::OFF_IRQ_RAW: prdata_nxt = raw_r;
      cmr_pkg::OFF_IRQ_MASKED: prdata_nxt = masked;
      default: prdata_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pclk0_r <= cmr_pkg::PCLK0_RST;
      pclk1_r <= 32'h00000000;
      mode0_r <= cmr_pkg::MODE0_RST;
      mode1_r <= cmr_pkg::MODE1_RST;
      mask_r <= 32'h00000000;
      raw_r <= cmr_pkg::IRQ_RAW_RST;
      boot_load_r <= 1'b1;
      prdata <= 32'h00000000;
    end else begin
      boot_load_r <= 1'b0;
      mode1_r <= mode1_nxt;
      if (boot_load_r) begin
        mode1_r[cmr_pkg::SYS_LSB +: 2] <= boot_clock_option;
      end
      raw_r <= raw_nxt;
      if (rd) begin
        prdata <= known_addr ? prdata_nxt : 32'h00000000;
      end
      if (wr && paddr == cmr_pkg::OFF_PCLK_SET0) begin
        pclk0_r <= pclk0_r | (pwdata & cmr_pkg::PCLK0_WMASK);
      end
      if (wr && paddr == cmr_pkg::OFF_PCLK_CLR0) begin
        pclk0_r <= pclk0_r & ~(pwdata & cmr_pkg::PCLK0_WMASK);
      end
      if (wr && paddr == cmr_pkg::OFF_PCLK_SET1) begin
        pclk1_r <= pclk1_r | (pwdata & cmr_pkg::PCLK1_WMASK);
      end
      if (wr && paddr == cmr_pkg::OFF_PCLK_CLR1) begin
        pclk1_r <= pclk1_r & ~(pwdata & cmr_pkg::PCLK1_WMASK);
      end
      if (wr && paddr == cmr_pkg::OFF_MODE0) begin
        mode0_r <= mode0_wr;
      end
      if (wr && paddr == cmr_pkg::OFF_IRQ_MASK) begin
        mask_r <= pwdata & cmr_pkg::IRQ_MASK_WMASK;
      end
    end
  end

  // event pulse fires once per rising edge of the enable bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      evt_arm_r <= 1'b0;
      processor_event_pulse <= 1'b0;
    end else begin
      evt_arm_r <= mode0_r[cmr_pkg::EVT_BIT];
      processor_event_pulse <= mode0_r[cmr_pkg::EVT_BIT] && !evt_arm_r;
    end
  end

  // gated clocks are what blocks peripheral register writes
  assign periph_clk_en0 = pclk0_r;
  assign periph_clk_en1 = pclk1_r;
  assign system_clock_select = mode1_r[cmr_pkg::SYS_LSB +: 3];
  assign system_clock_switching = sw_busy;
  assign watchdog_clock_select = mode1_r[cmr_pkg::WDT_LSB +: 3];
  assign freerun_timer_clock_select = mode1_r[cmr_pkg::FRT_LSB +: 3];
  assign stamp_timer_clock_select = mode1_r[cmr_pkg::STT_LSB +: 3];
  assign lcd_clock_select = mode1_r[cmr_pkg::LCD_LSB +: 3];
  assign clock_output_select = mode0_r[cmr_pkg::CLOCK_OUTPUT_SELECT_LSB +: 3];
  assign systick_clock_enable = mode0_r[cmr_pkg::SYSTICK_EN_BIT];
  assign command_error_flag = raw_r[cmr_pkg::IRQ_COMMAND_ERROR_FLAG];
endmodule

// ### cmr_clock_mode_regs_properties.sv
// port assertions for the clock mode register block
`timescale 1ns/10ps
module cmr_clock_mode_regs_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [4:0] src_enabled,
  input wire logic [31:0] periph_clk_en0,
  input wire logic [2:0] system_clock_select,
  input wire logic system_clock_switching,
  input wire logic [2:0] watchdog_clock_select,
  input wire logic [2:0] clock_output_select,
  input wire logic processor_event_pulse,
  input wire logic vdet_power_up,
  input wire logic vdet_chip_reset,
  input wire logic command_error_flag,
  input wire logic cm_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic wr = psel && penable && pwrite;
  wire logic wr_m0 = wr && paddr == cmr_pkg::OFF_MODE0;
  wire logic wr_m1 = wr && paddr == cmr_pkg::OFF_MODE1;
  wire logic w9 = wr_m0 && pwdata[9];
  // only legal codes can name a source whose enable is known
  wire logic wdt_bad = wr_m1 && pwdata[6:4] <= 3'h4 && !src_enabled[pwdata[6:4]];
  a_set_gate: assert property (wr && paddr == cmr_pkg::OFF_PCLK_SET0 |=>
    periph_clk_en0 == ($past(periph_clk_en0) | ($past(pwdata) & cmr_pkg::PCLK0_WMASK)))
    else $error("set word did not connect clocks");
  a_clr_gate: assert property (wr && paddr == cmr_pkg::OFF_PCLK_CLR0 |=>
    periph_clk_en0 == ($past(periph_clk_en0) & ~($past(pwdata) & cmr_pkg::PCLK0_WMASK)))
    else $error("clear word did not gate clocks");
  a_sys_prohib: assert property (wr_m1 && pwdata[2:0] > 3'h4 |=> $stable(system_clock_select))
    else $error("prohibited system code changed selector");
  a_wdt_keep: assert property (wdt_bad |=> $stable(watchdog_clock_select))
    else $error("disabled source taken by watchdog selector");
  a_cmd_err: assert property (wdt_bad |-> ##[1:2] command_error_flag)
    else $error("command error not raised");
  a_mask_off: assert property (wr && paddr == cmr_pkg::OFF_IRQ_MASK && pwdata == 32'h0 |=> !cm_irq)
    else $error("interrupt high with all sources masked");
  a_evt_single: assert property (processor_event_pulse |=> !processor_event_pulse)
    else $error("event pulse longer than one cycle");
  a_evt_cause: assert property (processor_event_pulse |-> $past(w9) || $past(w9, 2))
    else $error("event pulse without a write of the event bit");
  a_vdet_off: assert property (!vdet_power_up && $past(!vdet_power_up) |-> !vdet_chip_reset)
    else $error("detector reset while powered down");
  a_switch_end: assert property ($rose(system_clock_switching) |-> ##[1:40] !system_clock_switching)
    else $error("system clock switch never finished");
  a_clock_output_select_rsvd: assert property (wr_m0 && pwdata[14:12] == 3'h5 |=> $stable(clock_output_select))
    else $error("reserved output code accepted");
  c_switch: cover property ($fell(system_clock_switching));
  c_cmd_err: cover property ($rose(command_error_flag));
  c_vdet_rst: cover property ($rose(vdet_chip_reset));
endmodule

// ### test_cmr_clock_mode_regs.sv
// self-checking bench for the clock mode register block
`timescale 1ns/10ps
module test_cmr_clock_mode_regs;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] boot_clock_option = 2'h2;
  logic [4:0] src_enabled = 5'h0F;
  logic [4:0] src_stable_evt = 5'h00;
  logic [3:0] fail_evt = 4'h0;
  logic [3:0] vdet_level_crossed = 4'h0;
  logic [31:0] prdata, periph_clk_en0, periph_clk_en1;
  logic pready, pslverr, system_clock_switching, systick_clock_enable;
  logic processor_event_pulse, vdet_power_up, vdet_chip_reset, command_error_flag, cm_irq;
  logic [2:0] system_clock_select, watchdog_clock_select, freerun_timer_clock_select;
  logic [2:0] stamp_timer_clock_select, lcd_clock_select, clock_output_select;
  int err_total = 0;
  int comparisons = 0;
  int evt_cnt = 0;
  int seed = 32'h1EA8650C;
  logic [31:0] q, e, r, pc0, pc1, m0;
  cmr_clock_mode_regs u_cmr_clock_mode_regs (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .boot_clock_option(boot_clock_option),
    .src_enabled(src_enabled), .src_stable_evt(src_stable_evt), .fail_evt(fail_evt),
    .vdet_level_crossed(vdet_level_crossed), .periph_clk_en0(periph_clk_en0),
    .periph_clk_en1(periph_clk_en1), .system_clock_select(system_clock_select),
    .system_clock_switching(system_clock_switching),
    .watchdog_clock_select(watchdog_clock_select),
    .freerun_timer_clock_select(freerun_timer_clock_select),
    .stamp_timer_clock_select(stamp_timer_clock_select), .lcd_clock_select(lcd_clock_select),
    .clock_output_select(clock_output_select), .systick_clock_enable(systick_clock_enable),
    .processor_event_pulse(processor_event_pulse), .vdet_power_up(vdet_power_up),
    .vdet_chip_reset(vdet_chip_reset), .command_error_flag(command_error_flag), .cm_irq(cm_irq));
  always #4 clk = ~clk;
  always @(posedge clk) if (processor_event_pulse === 1'b1) evt_cnt <= evt_cnt + 1;
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected value at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask
  // one apb transfer; bus left idle one cycle so no signal is driven twice in a step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      stop_test();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int n;
    for (n = 0; n < 40 && s !== v; n++) @(posedge clk);
    chk(32'(s), 32'(v));
    if (s !== v) stop_test();
  endtask
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // a reserved output code leaves the old selection in place
  function automatic logic [31:0] mode0_exp(input logic [31:0] old, input logic [31:0] v);
    if (v[14:12] == cmr_pkg::CLOCK_OUTPUT_SELECT_RSVD) v[14:12] = old[14:12];
    return v & cmr_pkg::MODE0_WMASK;
  endfunction
  function automatic logic [31:0] mode1_val(input logic [2:0] sys, input logic [2:0] wdt);
    return {13'h0, 3'h2, 1'b0, 3'h0, 1'b0, 3'h3, 1'b0, wdt, 1'b0, sys};
  endfunction
  initial begin
    do_reset();
    rd(cmr_pkg::OFF_PCLK_STAT0, cmr_pkg::PCLK0_RST);
    rd(cmr_pkg::OFF_PCLK_STAT1, 32'h0);
    rd(cmr_pkg::OFF_MODE0, cmr_pkg::MODE0_RST);
    rd(cmr_pkg::OFF_MODE1, {cmr_pkg::MODE1_RST[31:2], boot_clock_option});
    rd(cmr_pkg::OFF_IRQ_MASK, 32'h0);
    rd(cmr_pkg::OFF_IRQ_RAW, cmr_pkg::IRQ_RAW_RST);
    rd(8'h44, 32'h0);
    $display("reset values test done");
    pc0 = cmr_pkg::PCLK0_RST;
    pc1 = 32'h0;
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      xfer(1'b1, cmr_pkg::OFF_PCLK_SET0, r);
      pc0 = pc0 | (r & cmr_pkg::PCLK0_WMASK);
      r = $random(seed);
      xfer(1'b1, cmr_pkg::OFF_PCLK_CLR0, r);
      pc0 = pc0 & ~(r & cmr_pkg::PCLK0_WMASK);
      r = $random(seed);
      xfer(1'b1, cmr_pkg::OFF_PCLK_SET1, r);
      pc1 = pc1 | (r & cmr_pkg::PCLK1_WMASK);
      xfer(1'b1, cmr_pkg::OFF_PCLK_CLR1, 32'h0);
      rd(cmr_pkg::OFF_PCLK_STAT0, pc0);
      rd(cmr_pkg::OFF_PCLK_STAT1, pc1);
      chk(periph_clk_en0, pc0);
      chk(periph_clk_en1, pc1);
    end
    $display("gating test done");
    r = $random(seed);
    xfer(1'b1, cmr_pkg::OFF_IRQ_MASK, r);
    rd(cmr_pkg::OFF_IRQ_MASK, r & cmr_pkg::IRQ_MASK_WMASK);
    rd(cmr_pkg::OFF_IRQ_MASKED, r & cmr_pkg::IRQ_MASK_WMASK & 32'h1F);
    xfer(1'b1, cmr_pkg::OFF_IRQ_MASK, 32'h00000010);
    xfer(1'b1, cmr_pkg::OFF_IRQ_MASKED, 32'hFFFFFFFF);
    chk(32'(cm_irq), 32'h1);
    xfer(1'b1, cmr_pkg::OFF_IRQ_CLEAR, 32'h0000000F);
    rd(cmr_pkg::OFF_IRQ_RAW, 32'h00000010);
    xfer(1'b1, cmr_pkg::OFF_IRQ_CLEAR, 32'h00000010);
    chk(32'(cm_irq), 32'h0);
    fail_evt <= 4'hF;
    src_stable_evt <= 5'h10;
    @(posedge clk);
    fail_evt <= 4'h0;
    src_stable_evt <= 5'h00;
    @(posedge clk);
    rd(cmr_pkg::OFF_IRQ_RAW, 32'h0000F080);
    xfer(1'b1, cmr_pkg::OFF_IRQ_MASK, 32'h0);
    $display("interrupt test done");
    m0 = cmr_pkg::MODE0_RST;
    for (int c = 0; c < 8; c++) begin
      r = $random(seed);
      r = {17'h0, 3'(c), 1'b1, r[10:9], 1'b0, r[7], 3'(3 + r[5:4]), r[3], 3'(3 + r[1:0])};
      xfer(1'b1, cmr_pkg::OFF_MODE0, r);
      m0 = mode0_exp(m0, r);
      rd(cmr_pkg::OFF_MODE0, m0);
      chk(32'(clock_output_select), 32'(m0[14:12]));
    end
    xfer(1'b1, cmr_pkg::OFF_MODE0, m0 & ~32'h200);
    e = evt_cnt;
    xfer(1'b1, cmr_pkg::OFF_MODE0, m0 | 32'h200);
    xfer(1'b1, cmr_pkg::OFF_MODE0, m0 | 32'h200);
    chk(evt_cnt - e, 32'h1);
    // equal levels with power down first, then power up
    vdet_level_crossed <= 4'hF;
    xfer(1'b1, cmr_pkg::OFF_MODE0, 32'h0000004C);
    repeat (4) @(posedge clk);
    chk(32'(vdet_chip_reset), 32'h0);
    chk(32'(vdet_power_up), 32'h0);
    xfer(1'b1, cmr_pkg::OFF_MODE0, 32'h0000084C);
    wait_for(vdet_chip_reset, 1'b1);
    vdet_level_crossed <= 4'h0;
    $display("mode test done");
    do_reset();
    e = {cmr_pkg::MODE1_RST[31:2], boot_clock_option};
    xfer(1'b1, cmr_pkg::OFF_MODE1, mode1_val(3'h2, 3'h4));
    rd(cmr_pkg::OFF_MODE1, e);
    chk(32'(command_error_flag), 32'h1);
    xfer(1'b1, cmr_pkg::OFF_IRQ_CLEAR, 32'h0004001F);
    xfer(1'b1, cmr_pkg::OFF_MODE1, mode1_val(3'h5, 3'h1));
    rd(cmr_pkg::OFF_MODE1, e);
    chk(32'(command_error_flag), 32'h0);
    xfer(1'b1, cmr_pkg::OFF_MODE1, mode1_val(3'h1, 3'h1));
    wait_for(system_clock_switching, 1'b0);
    // stable status lands one edge after busy drops
    @(posedge clk);
    rd(cmr_pkg::OFF_IRQ_RAW, 32'h00000010);
    chk(32'(system_clock_select), 32'h1);
    src_enabled <= 5'h1F;
    xfer(1'b1, cmr_pkg::OFF_MODE1, mode1_val(3'h1, 3'h4));
    rd(cmr_pkg::OFF_MODE1, mode1_val(3'h1, 3'h4));
    chk(32'(watchdog_clock_select), 32'h4);
    chk(32'(freerun_timer_clock_select), 32'h3);
    chk(32'(stamp_timer_clock_select), 32'h0);
    chk(32'(lcd_clock_select), 32'h2);
    $display("clock select test done");
    stop_test();
  end
endmodule
bind cmr_clock_mode_regs cmr_clock_mode_regs_chk u_cmr_clock_mode_regs_chk (.clk(clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .src_enabled(src_enabled), .periph_clk_en0(periph_clk_en0),
  .system_clock_select(system_clock_select), .system_clock_switching(system_clock_switching),
  .watchdog_clock_select(watchdog_clock_select), .clock_output_select(clock_output_select),
  .processor_event_pulse(processor_event_pulse), .vdet_power_up(vdet_power_up),
  .vdet_chip_reset(vdet_chip_reset), .command_error_flag(command_error_flag), .cm_irq(cm_irq));
